// File: hdl/lpm_pkg.sv
// Package for the low-power mode controller: mode encodings, bus map, carriers.
// Assumes a single 200 MHz AHB-Lite clock domain.
package lpm_pkg;

  // ----------------------------------------------------------------
  // Bus map
  // ----------------------------------------------------------------
  localparam logic [7:0] lpm_off_status_word = 8'h00;
  localparam logic [7:0] lpm_off_config = 8'h04;
  localparam logic [7:0] lpm_off_mode_state = 8'h08;
  localparam logic [7:0] lpm_off_stack_word = 8'h0c;
  localparam logic [7:0] lpm_off_wake_cause = 8'h10;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int lpm_bit_cpu_halt = 4;
  localparam int lpm_bit_osc_off = 5;
  localparam int lpm_bit_clock_generator_ctl_zero = 6;
  localparam int lpm_bit_clock_generator_ctl_one = 7;
  localparam int lpm_bit_subsystem_clock_off = 0;
  localparam int lpm_bit_reg_off = 1;
  localparam int lpm_bit_rtc_keep = 2;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [15:0] lpm_rst_status_word = 16'h0000;
  localparam logic [2:0] lpm_rst_config = 3'h0;
  localparam logic [15:0] lpm_mode_mask = 16'h00f0;
  localparam logic [15:0] lpm_isr_clear_mask = 16'h00b0;

  typedef enum logic [2:0] {
    lpm_active,
    lpm_sleep0,
    lpm_sleep2,
    lpm_sleep3,
    lpm_sleep4,
    lpm_deep35,
    lpm_deep45
  } lpm_mode_t;

  typedef enum logic [1:0] {
    lpm_run,
    lpm_deep,
    lpm_wake_rst
  } lpm_state_t;

  // Clock and power enables to the clock system
  typedef struct packed {
    logic cpu_run;
    logic mclk_en;
    logic subsystem_clock_en;
    logic aclk_en;
    logic dco_en;
    logic dco_bias_en;
    logic fll_en;
    logic regulator_en;
    logic rtc_domain_en;
  } lpm_enables_t;

  // Peripheral clock requests
  typedef struct packed {
    logic aclk_req;
    logic subsystem_clock_req;
  } lpm_clk_req_t;

  // Deep-mode wake sources
  typedef struct packed {
    logic power_seq;
    logic reset_pin;
    logic rtc_event;
    logic lfxt_fault;
    logic port_wake;
  } lpm_wake_t;

  // Clock source routing of the oscillator
  typedef struct packed {
    logic dco_src_aclk;
    logic dco_src_mclk;
    logic dco_src_subsystem_clock;
  } lpm_src_t;

endpackage : lpm_pkg

// File: hdl/lpm_ctrl.sv
// Low-power operating-mode controller with an AHB-Lite register port.
// Assumes core and peripherals on hclk; wake inputs are asynchronous.
`timescale 1ns/100ps
module lpm_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic irq_pending,
  input wire logic isr_enter,
  input wire logic isr_return,
  input wire lpm_pkg::lpm_clk_req_t clk_req,
  input wire lpm_pkg::lpm_src_t clk_src,
  input wire lpm_pkg::lpm_wake_t wake_async,
  output lpm_pkg::lpm_enables_t enables,
  output lpm_pkg::lpm_mode_t actual_mode,
  output logic periph_active,
  output logic retain_hold,
  output logic pin_latch,
  output logic state_lost,
  output logic brownout_level_reset
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] processor_status_word;
  logic [15:0] stack_word;
  logic [2:0] config_bits;
  logic [4:0] wake_cause;
  lpm_pkg::lpm_state_t state;
  lpm_pkg::lpm_wake_t wake_s1;
  lpm_pkg::lpm_wake_t wake_s2;
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic cpu_halt_bit;
  logic oscillator_off_bit;
  logic clock_generator_ctl_zero;
  logic clock_generator_ctl_one;
  logic subsystem_clock_off_bit;
  logic regulator_off_bit;
  lpm_pkg::lpm_mode_t req_mode;
  lpm_pkg::lpm_mode_t next_mode;
  lpm_pkg::lpm_enables_t next_enables;
  logic deep_wake;
  logic wr_psw;
  logic bus_take;
  logic wr_stk;
  logic [31:0] next_hrdata;
  logic wake_common;
  logic wake_rtc_side;

  assign subsystem_clock_off_bit = config_bits[lpm_pkg::lpm_bit_subsystem_clock_off];
  assign regulator_off_bit = config_bits[lpm_pkg::lpm_bit_reg_off];
  assign cpu_halt_bit = processor_status_word[lpm_pkg::lpm_bit_cpu_halt];
  assign oscillator_off_bit = processor_status_word[lpm_pkg::lpm_bit_osc_off];
  assign clock_generator_ctl_zero = processor_status_word[lpm_pkg::lpm_bit_clock_generator_ctl_zero];
  assign clock_generator_ctl_one = processor_status_word[lpm_pkg::lpm_bit_clock_generator_ctl_one];

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  assign bus_take = hsel && hready && htrans[1];
  // Zero wait states; every transfer answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_psw = ph_valid && ph_write && (ph_addr == lpm_pkg::lpm_off_status_word);
  assign wr_stk = ph_valid && ph_write && (ph_addr == lpm_pkg::lpm_off_stack_word);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_valid <= bus_take;
      ph_write <= hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb begin
    next_hrdata = 32'h0000_0000;
    if (haddr[7:0] == lpm_pkg::lpm_off_status_word) begin
      next_hrdata = {16'h0000, processor_status_word};
    end else if (haddr[7:0] == lpm_pkg::lpm_off_config) begin
      next_hrdata = {29'h0000_0000, config_bits};
    end else if (haddr[7:0] == lpm_pkg::lpm_off_mode_state) begin
      next_hrdata = {22'h00_0000, state, actual_mode, enables[8:4]};
    end else if (haddr[7:0] == lpm_pkg::lpm_off_stack_word) begin
      next_hrdata = {16'h0000, stack_word};
    end else if (haddr[7:0] == lpm_pkg::lpm_off_wake_cause) begin
      next_hrdata = {27'h000_0000, wake_cause};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_take && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      config_bits <= lpm_pkg::lpm_rst_config;
    end else if (ph_valid && ph_write && ph_addr == lpm_pkg::lpm_off_config) begin
      config_bits <= hwdata[2:0];
    end
  end

  // ----------------------------------------------------------------
  // Status word and interrupt stack
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      processor_status_word <= lpm_pkg::lpm_rst_status_word;
    end else if (state == lpm_pkg::lpm_wake_rst) begin
      processor_status_word <= lpm_pkg::lpm_rst_status_word;
    end else if (isr_enter) begin
      processor_status_word <= processor_status_word & ~lpm_pkg::lpm_isr_clear_mask;
    end else if (isr_return) begin
      processor_status_word <= stack_word;
    end else if (wr_psw && state == lpm_pkg::lpm_run) begin
      processor_status_word <= hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stack_word <= lpm_pkg::lpm_rst_status_word;
    end else if (state == lpm_pkg::lpm_wake_rst) begin
      stack_word <= lpm_pkg::lpm_rst_status_word;
    end else if (isr_enter) begin
      stack_word <= processor_status_word;
    end else if (wr_stk && !isr_return) begin
      // Bus write loses to an interrupt entry or return
      stack_word <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    req_mode = lpm_pkg::lpm_active;
    if (!cpu_halt_bit) begin
      req_mode = lpm_pkg::lpm_active;
    end else if (oscillator_off_bit && clock_generator_ctl_zero && clock_generator_ctl_one) begin
      if (regulator_off_bit) begin
        req_mode = config_bits[lpm_pkg::lpm_bit_rtc_keep] ? lpm_pkg::lpm_deep35
                                                          : lpm_pkg::lpm_deep45;
      end else begin
        req_mode = lpm_pkg::lpm_sleep4;
      end
    end else if (clock_generator_ctl_one && !oscillator_off_bit) begin
      req_mode = clock_generator_ctl_zero ? lpm_pkg::lpm_sleep3 : lpm_pkg::lpm_sleep2;
    end else begin
      req_mode = lpm_pkg::lpm_sleep0;
    end
  end

  always_comb begin
    next_mode = req_mode;
    if (req_mode != lpm_pkg::lpm_active && req_mode != lpm_pkg::lpm_deep35
        && req_mode != lpm_pkg::lpm_deep45) begin
      if (clk_req.subsystem_clock_req) begin
        next_mode = lpm_pkg::lpm_sleep0;
      end else if (clk_req.aclk_req && req_mode == lpm_pkg::lpm_sleep4) begin
        next_mode = lpm_pkg::lpm_sleep3;
      end
    end
    if (state == lpm_pkg::lpm_wake_rst) begin
      next_mode = lpm_pkg::lpm_active;
    end
  end

  // ----------------------------------------------------------------
  // Clock enables
  // ----------------------------------------------------------------
  always_comb begin
    next_enables = '0;
    next_enables.regulator_en = 1'b1;
    case (next_mode)
      lpm_pkg::lpm_active: begin
        next_enables.cpu_run = 1'b1;
        next_enables.mclk_en = 1'b1;
        next_enables.aclk_en = 1'b1;
        next_enables.subsystem_clock_en = !subsystem_clock_off_bit || clk_req.subsystem_clock_req;
        next_enables.dco_en = clk_src.dco_src_aclk || clk_src.dco_src_mclk
                              || (clk_src.dco_src_subsystem_clock && next_enables.subsystem_clock_en);
      end
      lpm_pkg::lpm_sleep0: begin
        next_enables.aclk_en = 1'b1;
        next_enables.subsystem_clock_en = !subsystem_clock_off_bit || clk_req.subsystem_clock_req;
        next_enables.dco_en = clk_src.dco_src_aclk
                              || (clk_src.dco_src_subsystem_clock && next_enables.subsystem_clock_en);
      end
      lpm_pkg::lpm_sleep2, lpm_pkg::lpm_sleep3: begin
        next_enables.aclk_en = 1'b1;
      end
      lpm_pkg::lpm_deep35: begin
        next_enables.regulator_en = 1'b0;
        next_enables.rtc_domain_en = 1'b1;
      end
      lpm_pkg::lpm_deep45: begin
        next_enables.regulator_en = 1'b0;
      end
      lpm_pkg::lpm_sleep4: begin
        next_enables.regulator_en = 1'b1;
      end
      default: begin
        next_enables.regulator_en = 1'b1;
      end
    endcase
    if (next_mode == lpm_pkg::lpm_active || next_mode == lpm_pkg::lpm_sleep0) begin
      next_enables.dco_bias_en = next_enables.dco_en || clk_src.dco_src_mclk
                                 || (clk_src.dco_src_subsystem_clock && next_enables.subsystem_clock_en);
      next_enables.fll_en = next_enables.dco_en;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // registered each cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enables <= '0;
    end else begin
      enables <= next_enables;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      actual_mode <= lpm_pkg::lpm_active;
    end else begin
      actual_mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // peripherals idle while their clock is off
  assign periph_active = enables.subsystem_clock_en;
  assign retain_hold = enables.regulator_en && !enables.cpu_run;

  // ----------------------------------------------------------------
  // Deep mode sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_s1 <= '0;
      wake_s2 <= '0;
    end else begin
      wake_s1 <= wake_async;
      wake_s2 <= wake_s1;
    end
  end

  // sources that wake either deep mode
  assign wake_common = wake_s2.power_seq || wake_s2.reset_pin || wake_s2.port_wake;
  assign wake_rtc_side = wake_s2.rtc_event || wake_s2.lfxt_fault;

  always_comb begin
    deep_wake = 1'b0;
    if (actual_mode == lpm_pkg::lpm_deep45) begin
      deep_wake = wake_common;
    end else if (actual_mode == lpm_pkg::lpm_deep35) begin
      deep_wake = wake_common || wake_rtc_side;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= lpm_pkg::lpm_run;
    end else begin
      case (state)
        lpm_pkg::lpm_run: begin
          if (actual_mode == lpm_pkg::lpm_deep35 || actual_mode == lpm_pkg::lpm_deep45) begin
            state <= lpm_pkg::lpm_deep;
          end
        end
        lpm_pkg::lpm_deep: begin
          if (deep_wake) begin
            state <= lpm_pkg::lpm_wake_rst;
          end
        end
        lpm_pkg::lpm_wake_rst: begin
          state <= lpm_pkg::lpm_run;
        end
        default: begin
          state <= lpm_pkg::lpm_run;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_cause <= 5'h00;
    end else if (state == lpm_pkg::lpm_deep && deep_wake) begin
      wake_cause <= wake_s2;
    end
  end

  assign pin_latch = (state == lpm_pkg::lpm_deep);
  assign state_lost = (state == lpm_pkg::lpm_deep);
  assign brownout_level_reset = (state == lpm_pkg::lpm_wake_rst);

endmodule : lpm_ctrl

// File: test/lpm_ctrl_chk.sv
// Checker: mode to enable relations and deep-mode exit of lpm_ctrl.
// Bound into lpm_ctrl; sees its ports only.
`timescale 1ns/100ps
module lpm_ctrl_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire lpm_pkg::lpm_enables_t enables,
  input wire lpm_pkg::lpm_mode_t actual_mode,
  input wire logic pin_latch,
  input wire logic state_lost,
  input wire logic brownout_level_reset
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic rdy;
  logic run0;
  logic deep;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Skips the first edge, where outputs still hold reset values
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rdy <= 1'b0;
    else rdy <= 1'b1;
  end
  assign run0 = actual_mode == lpm_pkg::lpm_active || actual_mode == lpm_pkg::lpm_sleep0;
  assign deep = actual_mode == lpm_pkg::lpm_deep35 || actual_mode == lpm_pkg::lpm_deep45;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_active;
    rdy && actual_mode == lpm_pkg::lpm_active |-> enables.cpu_run && enables.mclk_en
      && enables.aclk_en;
  endproperty
  a_active: assert property (p_active) else $error("active mode clock off");
  property p_sleep0;
    rdy && actual_mode == lpm_pkg::lpm_sleep0 |-> !enables.cpu_run && !enables.mclk_en
      && enables.aclk_en;
  endproperty
  a_sleep0: assert property (p_sleep0) else $error("sleep zero clocks wrong");
  property p_sleep23;
    rdy && (actual_mode == lpm_pkg::lpm_sleep2 || actual_mode == lpm_pkg::lpm_sleep3)
      |-> enables[8:6] == 3'h0 && enables.aclk_en && !enables.fll_en;
  endproperty
  a_sleep23: assert property (p_sleep23) else $error("sleep two or three clocks wrong");
  property p_sleep4;
    rdy && actual_mode == lpm_pkg::lpm_sleep4 |-> enables[8:2] == 7'h00;
  endproperty
  a_sleep4: assert property (p_sleep4) else $error("sleep four clock running");
  property p_fll;
    rdy && run0 |-> enables.fll_en == enables.dco_en;
  endproperty
  a_fll: assert property (p_fll) else $error("loop does not follow oscillator");
  property p_bias;
    rdy && run0 && enables.dco_en |-> enables.dco_bias_en;
  endproperty
  a_bias: assert property (p_bias) else $error("bias off with oscillator on");
  property p_reg;
    rdy && deep |-> ##[0:2] !enables.regulator_en;
  endproperty
  a_reg: assert property (p_reg) else $error("regulator on in deep mode");
  property p_latch;
    rdy && $rose(deep) |-> ##[0:2] pin_latch && state_lost;
  endproperty
  a_latch: assert property (p_latch) else $error("pins not latched on deep entry");
  property p_bor;
    brownout_level_reset |-> $past(pin_latch) ##1 !brownout_level_reset;
  endproperty
  a_bor: assert property (p_bor) else $error("brownout pulse wrong");
  c_sleep0: cover property (actual_mode == lpm_pkg::lpm_sleep0);
  c_deep35: cover property (actual_mode == lpm_pkg::lpm_deep35);
  c_bor: cover property (brownout_level_reset);
endmodule : lpm_ctrl_chk

bind lpm_ctrl lpm_ctrl_chk u_lpm_ctrl_chk (.hclk(hclk), .hresetn(hresetn),
  .enables(enables), .actual_mode(actual_mode), .pin_latch(pin_latch),
  .state_lost(state_lost), .brownout_level_reset(brownout_level_reset));

// File: test/lpm_core_model.sv
// Core and peripheral stand-in: interrupt entry and return, clock requests.
// Drives on the rising edge of hclk; the bench calls its tasks.
`timescale 1ns/100ps
module lpm_core_model (
  input wire logic hclk,
  output logic irq_pending,
  output logic isr_enter,
  output logic isr_return,
  output lpm_pkg::lpm_clk_req_t clk_req,
  output lpm_pkg::lpm_src_t clk_src
);
  initial begin
    irq_pending = 1'b0;
    isr_enter = 1'b0;
    isr_return = 1'b0;
    clk_req = '0;
    clk_src = '0;
  end
  task automatic set_clk(input lpm_pkg::lpm_clk_req_t r, input lpm_pkg::lpm_src_t s);
    @(posedge hclk);
    clk_req <= r;
    clk_src <= s;
  endtask : set_clk
  task automatic isr(input logic ret);
    @(posedge hclk);
    irq_pending <= ~ret;
    isr_enter <= ~ret;
    isr_return <= ret;
    @(posedge hclk);
    isr_enter <= 1'b0;
    isr_return <= 1'b0;
  endtask : isr
endmodule : lpm_core_model

// File: test/low_power_mode_control_tb.sv
// Self-checking bench for lpm_ctrl: modes, requests, interrupts, deep modes.
// Drives the AHB-Lite port directly; core stand-in gives pulses and requests.
`timescale 1ns/100ps
module low_power_mode_control_tb;
  localparam logic [7:0] a_psw = lpm_pkg::lpm_off_status_word;
  localparam logic [7:0] a_cfg = lpm_pkg::lpm_off_config;
  localparam logic [7:0] a_stk = lpm_pkg::lpm_off_stack_word;
  localparam logic [7:0] a_wak = lpm_pkg::lpm_off_wake_cause;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_pending, isr_enter, isr_return;
  logic periph_active, retain_hold, pin_latch, state_lost, brownout_level_reset;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  lpm_pkg::lpm_clk_req_t clk_req;
  lpm_pkg::lpm_src_t clk_src;
  lpm_pkg::lpm_wake_t wake_async;
  lpm_pkg::lpm_enables_t enables;
  lpm_pkg::lpm_mode_t actual_mode;
  int failures, n_tests;
  lpm_ctrl u_lpm_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_pending(irq_pending),
    .isr_enter(isr_enter), .isr_return(isr_return), .clk_req(clk_req), .clk_src(clk_src),
    .wake_async(wake_async), .enables(enables), .actual_mode(actual_mode),
    .periph_active(periph_active), .retain_hold(retain_hold), .pin_latch(pin_latch),
    .state_lost(state_lost), .brownout_level_reset(brownout_level_reset));
  lpm_core_model u_lpm_core_model (.hclk(hclk), .irq_pending(irq_pending),
    .isr_enter(isr_enter), .isr_return(isr_return), .clk_req(clk_req), .clk_src(clk_src));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic bus_wait;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      failures++;
      test_done();
    end
  endtask : bus_wait
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask : bus
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  task automatic t_reset;
    bus(1'b0, a_psw, 32'h0);
    chk("psw reset", 32'h0, rd);
    bus(1'b1, 8'h20, 32'hffffffff);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("ready resp", 32'h2, {30'h0, hreadyout, hresp});
  endtask : t_reset
  // every active and sleep mode, source and subsystem clock off bit
  task automatic t_modes;
    lpm_pkg::lpm_enables_t e;
    logic [8:0] m;
    logic [7:0] psw [5] = '{8'h00, 8'h10, 8'h90, 8'hd0, 8'hf0};
    logic sm;
    logic r0;
    for (int k = 0; k < 5; k++) begin
      for (int c = 0; c < 16; c++) begin
        u_lpm_core_model.set_clk(2'b00, c[2:0]);
        bus(1'b1, a_cfg, {31'h0, c[3]});
        bus(1'b1, a_psw, {24'h0, psw[k]});
        settle(4);
        r0 = k < 2;
        sm = c[0] & ~c[3];
        e = '0;
        e.cpu_run = k == 0;
        e.mclk_en = k == 0;
        e.subsystem_clock_en = r0 & ~c[3];
        e.aclk_en = k != 4;
        e.dco_en = r0 & (c[2] | sm | (k == 0 & c[1]));
        e.dco_bias_en = e.dco_en | (r0 & (c[1] | sm));
        e.fll_en = e.dco_en;
        e.regulator_en = 1'b1;
        m = (k == 2 || k == 3) ? 9'h1e6 : 9'h1fe;
        chk("mode", 32'(lpm_pkg::lpm_mode_t'(k)), 32'(actual_mode));
        chk("enables", 32'(e & m), 32'(enables & m));
        chk("retain", 32'(k != 0), 32'(retain_hold));
        chk("periph", 32'(e.subsystem_clock_en), 32'(periph_active));
      end
    end
  endtask : t_modes
  task automatic t_req;
    lpm_pkg::lpm_mode_t ex [4] = '{lpm_pkg::lpm_sleep4, lpm_pkg::lpm_sleep0,
      lpm_pkg::lpm_sleep3, lpm_pkg::lpm_sleep0};
    bus(1'b1, a_cfg, 32'h0);
    bus(1'b1, a_psw, 32'hf0);
    for (int r = 0; r < 4; r++) begin
      u_lpm_core_model.set_clk(r[1:0], 3'b000);
      settle(4);
      chk("req mode", 32'(ex[r]), 32'(actual_mode));
      chk("req periph", 32'(r[0]), 32'(periph_active));
    end
    bus(1'b1, a_cfg, 32'h1);
    bus(1'b1, a_psw, 32'h0);
    u_lpm_core_model.set_clk(2'b01, 3'b000);
    settle(4);
    chk("req active subsystem_clock", 32'h1, 32'(enables.subsystem_clock_en));
    chk("req active periph", 32'h1, 32'(periph_active));
    u_lpm_core_model.set_clk(2'b00, 3'b000);
    settle(4);
    chk("subsystem_clock off bit", 32'h0, 32'(enables.subsystem_clock_en));
    chk("periph gated", 32'h0, 32'(periph_active));
  endtask : t_req
  task automatic t_isr;
    bus(1'b1, a_psw, 32'hd0);
    settle(4);
    u_lpm_core_model.isr(1'b0);
    settle(4);
    bus(1'b0, a_psw, 32'h0);
    chk("psw entry", 32'h40, rd);
    chk("isr wake mode", 32'(lpm_pkg::lpm_active), 32'(actual_mode));
    bus(1'b0, a_stk, 32'h0);
    chk("stacked", 32'hd0, rd);
    bus(1'b1, a_stk, 32'h10);
    u_lpm_core_model.isr(1'b1);
    settle(4);
    chk("return mode", 32'(lpm_pkg::lpm_sleep0), 32'(actual_mode));
  endtask : t_isr
  task automatic t_deep(input logic [2:0] cfg, input logic [4:0] bad, input logic [4:0] good,
    input lpm_pkg::lpm_mode_t md);
    int n;
    bus(1'b1, a_cfg, {29'h0, cfg});
    bus(1'b1, a_psw, 32'hf0);
    settle(4);
    chk("deep mode", 32'(md), 32'(actual_mode));
    chk("regulator", 32'h0, 32'(enables.regulator_en));
    chk("latch lost", 32'h3, {30'h0, pin_latch, state_lost});
    @(posedge hclk);
    wake_async <= bad;
    settle(10);
    chk("no wake", 32'(md), 32'(actual_mode));
    @(posedge hclk);
    wake_async <= good;
    n = 0;
    while (brownout_level_reset !== 1'b1 && n < 40) begin
      settle(1);
      n++;
    end
    chk("brownout", 32'h1, 32'(brownout_level_reset));
    if (n >= 40) test_done();
    @(posedge hclk);
    wake_async <= '0;
    settle(4);
    chk("wake mode", 32'(lpm_pkg::lpm_active), 32'(actual_mode));
    chk("latch released", 32'h0, {30'h0, pin_latch, state_lost});
    bus(1'b0, a_psw, 32'h0);
    chk("psw lost", 32'h0, rd);
    bus(1'b0, a_wak, 32'h0);
    chk("wake cause", {27'h0, good}, rd);
  endtask : t_deep
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = '0;
    wake_async = '0;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_modes();
    t_req();
    t_isr();
    t_deep(3'h6, 5'h00, 5'h04, lpm_pkg::lpm_deep35);
    t_deep(3'h6, 5'h00, 5'h02, lpm_pkg::lpm_deep35);
    t_deep(3'h6, 5'h00, 5'h08, lpm_pkg::lpm_deep35);
    t_deep(3'h2, 5'h06, 5'h01, lpm_pkg::lpm_deep45);
    t_deep(3'h2, 5'h06, 5'h10, lpm_pkg::lpm_deep45);
    test_done();
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
endmodule : low_power_mode_control_tb
